//--- rtmch_mode_code_handler.sv
// Behaviour
// - after status for transmitter shutdown, block transmitter of the alternate channel
// - shut transmitter re-enabled only by override, reset mode code, soft or master clear
// - override shutdown replies status, then re-enables alternate transmitter
// - inhibit terminal flag replies status, then stops terminal flag being set
// - broadcast inhibit sets broadcast bit, keeps terminal flag, sends no status
// - override inhibit replies status and lets terminal flag be set again
// - reset mode code replies status, clears error, broadcast, test word, shutdown, inhibit
// - broadcast reset sends no status, sets broadcast bit, keeps loopback terminal flag
// - internal reset completes about 8 us after the command
// - enhanced mode with pulse select gives two-cycle low pulse on reset output
// - reserved transmit codes reply status, message error if marked illegal
// - transmit vector word sends status plus word from 0x120 or lookup block
// - receive vector word with data replies status, stores word at 0x110 or block
// - synchronize stores data word at 0x111 or receive lookup block
// - sync word loads time tag when enabled, only with zero lsb in enhanced sync
// - transmit sync without data replies status plus word from 0x121 or block
// - transmit last command sends old status and previous non-repeat command
// - receive last command stores word at 0x112, broadcast at 0x132 quietly
// - invalid command is ignored with no reply
// - data after data-less mode code: no status, message error, high word count
// - transmit-only code with receive bit: no status, error, contents error, broadcast
// - broadcast of an allowed mode code sets broadcast bit and sends no status
// - enhanced mode codes need both enhanced mode and enhanced handling bits
`timescale 1ns/1ps
`default_nettype none
module rtmch_mode_code_handler
  import rtmch_pkg::*;
#(
  parameter int RST_DELAY_CYCLES = RT_RESET_DELAY_CYC
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic msg_valid, // message complete pulse
  input wire logic [15:0] msg_cmd, // received command word
  input wire logic msg_sync_ok, // command sync pattern good
  input wire logic msg_manch_ok, // command manchester good
  input wire logic msg_parity_ok, // command parity good
  input wire logic [1:0] msg_words, // data words: 0, 1, 2 = more
  input wire logic [15:0] msg_data, // first data word
  input wire logic msg_channel, // channel of message, 0 = a
  input wire logic loop_fail, // loopback failure pulse
  output logic tx_req, // start reply pulse
  output logic tx_with_data, // reply carries a data word
  output logic [15:0] tx_data, // reply data word
  input wire logic tx_done, // reply transmission finished pulse
  output logic [1:0] tx_shutdown, // per channel transmitter blocked
  output logic status_me, // message error status bit
  output logic status_bcast, // broadcast received status bit
  output logic status_tf, // terminal flag status bit
  output logic [15:0] bit_word, // built-in-test word
  output logic ram_req, // ram request
  output logic ram_we, // ram write
  output logic [15:0] ram_addr, // ram address
  output logic [15:0] ram_wdata, // ram write data
  input wire logic [15:0] ram_rdata, // ram read data, valid with ack
  input wire logic ram_ack, // ram done pulse
  output logic time_tag_load, // time tag load pulse
  output logic [15:0] time_tag_value, // time tag load value
  input wire logic hardware_master_clear_in, // master clear pin, active high
  output logic reset_pulse_out_n // reset pulse, active low
);

  if (RST_DELAY_CYCLES < 1 || RST_DELAY_CYCLES > 255) begin : g_bad_delay
    $error("RST_DELAY_CYCLES must be 1 to 255");
  end

  typedef struct packed {
    rtmch_state_t st;
    rtmch_post_t post;
    logic [7:0] cnt;
    logic [1:0] pls;
    logic rpo_n;
    logic me;
    logic bcast;
    logic tf;
    logic tf_inh;
    logic tf_loop;
    logic tf_keep;
    logic [1:0] tx_off;
    logic [15:0] bitw;
    logic [15:0] last_cmd;
    logic ch;
    logic quiet;
    logic send_data;
    logic [15:0] tx_data;
    logic tx_req;
    logic ram_req;
    logic ram_we;
    logic [15:0] ram_addr;
    logic [15:0] ram_wdata;
    logic tt_load;
    logic [15:0] tt_value;
    logic [15:0] cfg2;
    logic [15:0] cfg3;
    logic [15:0] cfg7;
    logic [4:0] own_addr;
    logic [15:0] illegal;
    logic [15:0] ptr_tx;
    logic [15:0] ptr_rx;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] mclr_s;
    logic mclr;
  } rtmch_regs_t;

  rtmch_regs_t r;
  rtmch_regs_t next_r;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic reg_known(input logic [7:0] a);
    case (a)
      REG_START, REG_CFG2, REG_CFG3, REG_CFG7, REG_RTADDR, REG_ILLEGAL,
      REG_PTR_TX, REG_PTR_RX, REG_STATUS, REG_BITW, REG_LASTCMD: reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  endfunction : reg_known

  function automatic rtmch_post_t post_of(input logic [4:0] mc);
    case (mc)
      MC_SHUT: post_of = PA_SHUT;
      MC_UNSHUT: post_of = PA_UNSHUT;
      MC_INH: post_of = PA_INH;
      MC_UNINH: post_of = PA_UNINH;
      default: post_of = PA_NONE;
    endcase
  endfunction : post_of

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [4:0] mc;
  logic [4:0] sa;
  logic [4:0] addr;
  logic tr;
  logic bc;
  logic enh;
  logic cmd_ok;
  logic acc;

  assign mc = msg_cmd[CMD_MC_HI:CMD_MC_LO];
  assign sa = msg_cmd[CMD_SA_HI:CMD_SA_LO];
  assign addr = msg_cmd[CMD_ADDR_HI:CMD_ADDR_LO];
  assign tr = msg_cmd[CMD_TR];
  assign bc = (addr == BCAST_ADDR);
  assign enh = r.cfg3[CFG3_ENH_MODE] && r.cfg3[CFG3_ENH_MC];
  assign cmd_ok = msg_sync_ok && msg_manch_ok && msg_parity_ok
                  && (bc || addr == r.own_addr);
  // invalid commands never reach acc, so nothing answers them
  assign acc = msg_valid && (r.st == ST_IDLE) && cmd_ok
               && (sa == SA_MODE_A || sa == SA_MODE_B)
               && (mc >= MC_SHUT) && (mc <= MC_TLC);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic soft_rst;
  logic do_post;
  logic post_ch;
  rtmch_post_t post_sel;

  always_comb
  begin
    next_r = r;
    soft_rst = 1'b0;
    do_post = 1'b0;
    post_ch = r.ch;
    post_sel = PA_NONE;
    next_r.tx_req = 1'b0;
    next_r.tt_load = 1'b0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;

    // master clear pin filter
    next_r.mclr_s = {r.mclr_s[1:0], hardware_master_clear_in};
    if (r.mclr_s[1] == r.mclr_s[2])
    begin
      next_r.mclr = r.mclr_s[2];
    end

    // reset pulse countdown
    if (!r.rpo_n)
    begin
      if (r.pls == 2'h0)
      begin
        next_r.rpo_n = 1'b1;
      end
      else
      begin
        next_r.pls = r.pls - 2'h1;
      end
    end

    // apb setup phase: answer is ready in the access phase
    if (psel && !penable)
    begin
      next_r.pready = 1'b1;
      next_r.pslverr = !reg_known(paddr);
      next_r.prdata = '0;
      case (paddr)
        REG_CFG2: next_r.prdata[15:0] = r.cfg2;
        REG_CFG3: next_r.prdata[15:0] = r.cfg3;
        REG_CFG7: next_r.prdata[15:0] = r.cfg7;
        REG_RTADDR: next_r.prdata[4:0] = r.own_addr;
        REG_ILLEGAL: next_r.prdata[15:0] = r.illegal;
        REG_PTR_TX: next_r.prdata[15:0] = r.ptr_tx;
        REG_PTR_RX: next_r.prdata[15:0] = r.ptr_rx;
        REG_STATUS: next_r.prdata[6:0] = {r.st != ST_IDLE, r.tx_off, r.tf_inh,
                                          r.tf, r.bcast, r.me};
        REG_BITW: next_r.prdata[15:0] = r.bitw;
        REG_LASTCMD: next_r.prdata[15:0] = r.last_cmd;
        default: next_r.prdata = '0;
      endcase
    end

    // apb write takes effect at the access edge
    if (psel && penable && r.pready && pwrite && !r.pslverr)
    begin
      case (paddr)
        REG_START: soft_rst = pwdata[START_SOFT_RST];
        REG_CFG2: next_r.cfg2 = pwdata[15:0];
        REG_CFG3: next_r.cfg3 = pwdata[15:0];
        REG_CFG7: next_r.cfg7 = pwdata[15:0];
        REG_RTADDR: next_r.own_addr = pwdata[4:0];
        REG_ILLEGAL: next_r.illegal = pwdata[15:0];
        REG_PTR_TX: next_r.ptr_tx = pwdata[15:0];
        REG_PTR_RX: next_r.ptr_rx = pwdata[15:0];
        default: soft_rst = 1'b0;
      endcase
    end

    case (r.st)
      ST_IDLE:
      begin
        if (acc)
        begin
          if (mc != MC_TLC)
          begin
            next_r.last_cmd = msg_cmd;
            next_r.me = 1'b0;
            next_r.bcast = 1'b0;
          end
          next_r.ch = msg_channel;
          next_r.post = PA_NONE;
          next_r.send_data = 1'b0;
          next_r.quiet = bc;
          next_r.tf_keep = r.tf_loop;
          next_r.tf_loop = 1'b0;
          if (mc <= MC_RSV_HI)
          begin
            if (!tr)
            begin
              next_r.me = 1'b1;
              next_r.bitw[BITW_CCE] = 1'b1;
              next_r.bcast = bc;
            end
            else if (msg_words != WC_NONE)
            begin
              next_r.me = 1'b1;
              next_r.bitw[BITW_HWC] = 1'b1;
            end
            else if (bc && mc > MC_RST)
            begin
              next_r.me = 1'b1;
              next_r.bcast = 1'b1;
              next_r.bitw[BITW_CCE] = 1'b1;
            end
            else if (mc == MC_RST)
            begin
              next_r.bcast = bc;
              next_r.cnt = RST_DELAY_CYCLES[7:0];
              next_r.st = ST_RST;
            end
            else if (bc)
            begin
              next_r.bcast = 1'b1;
              do_post = 1'b1;
              post_ch = msg_channel;
              post_sel = post_of(mc);
            end
            else
            begin
              if (mc >= MC_RSV_LO && r.illegal[mc[3:0]])
              begin
                next_r.me = 1'b1;
              end
              next_r.post = post_of(mc);
              next_r.tx_req = 1'b1;
              next_r.st = ST_SEND;
            end
          end
          else if (tr)
          begin
            if (msg_words != WC_NONE)
            begin
              next_r.me = 1'b1;
              next_r.bitw[BITW_HWC] = 1'b1;
            end
            else if (bc)
            begin
              next_r.me = 1'b1;
              next_r.bcast = 1'b1;
              next_r.bitw[BITW_CCE] = 1'b1;
            end
            else if (mc == MC_TLC)
            begin
              next_r.tx_data = r.last_cmd;
              next_r.send_data = 1'b1;
              next_r.tx_req = 1'b1;
              next_r.st = ST_SEND;
            end
            else
            begin
              next_r.ram_req = 1'b1;
              next_r.ram_we = 1'b0;
              next_r.ram_addr = !enh ? r.ptr_tx
                                : (mc == MC_TVW) ? RAM_TVW_TX : RAM_SYNC_TX;
              next_r.send_data = 1'b1;
              next_r.st = ST_RAM;
            end
          end
          else if (msg_words != WC_ONE)
          begin
            next_r.me = 1'b1;
            next_r.bcast = bc;
            if (msg_words == WC_NONE)
            begin
              next_r.bitw[BITW_LWC] = 1'b1;
            end
            else
            begin
              next_r.bitw[BITW_HWC] = 1'b1;
            end
          end
          else
          begin
            next_r.bcast = bc;
            next_r.ram_req = 1'b1;
            next_r.ram_we = 1'b1;
            next_r.ram_wdata = msg_data;
            if (mc == MC_TLC)
            begin
              next_r.ram_addr = bc ? RAM_TLC_BC : RAM_TLC_RX;
            end
            else if (!enh)
            begin
              next_r.ram_addr = r.ptr_rx;
            end
            else
            begin
              next_r.ram_addr = (mc == MC_TVW) ? RAM_TVW_RX : RAM_SYNC_RX;
            end
            if (mc == MC_SYNC && r.cfg2[CFG2_LOAD_TT]
                && !(r.cfg7[CFG7_ENH_TT] && msg_data[0]))
            begin
              next_r.tt_load = 1'b1;
              next_r.tt_value = msg_data;
            end
            next_r.st = ST_RAM;
          end
        end
      end
      ST_RAM:
      begin
        if (ram_ack)
        begin
          next_r.ram_req = 1'b0;
          if (!r.ram_we)
          begin
            next_r.tx_data = ram_rdata;
          end
          if (r.quiet)
          begin
            next_r.st = ST_IDLE;
          end
          else
          begin
            next_r.tx_req = 1'b1;
            next_r.st = ST_SEND;
          end
        end
      end
      ST_SEND:
      begin
        if (tx_done)
        begin
          do_post = 1'b1;
          post_sel = r.post;
          next_r.st = ST_IDLE;
        end
      end
      ST_RST:
      begin
        if (r.cnt > 8'h01)
        begin
          next_r.cnt = r.cnt - 8'h01;
        end
        else
        begin
          next_r.me = 1'b0;
          next_r.bcast = r.quiet;
          next_r.bitw = '0;
          next_r.tx_off = '0;
          next_r.tf_inh = 1'b0;
          next_r.tf = r.quiet && r.tf_keep && r.tf;
          if (r.cfg3[CFG3_ENH_MODE] && r.cfg7[CFG7_RST_PULSE])
          begin
            next_r.rpo_n = 1'b0;
            next_r.pls = 2'(RST_PULSE_CYC - 1);
          end
          next_r.send_data = 1'b0;
          if (r.quiet)
          begin
            next_r.st = ST_IDLE;
          end
          else
          begin
            next_r.tx_req = 1'b1;
            next_r.st = ST_SEND;
          end
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    // actions that follow the reply, or a broadcast at once
    if (do_post)
    begin
      case (post_sel)
        PA_SHUT: next_r.tx_off[!post_ch] = 1'b1;
        PA_UNSHUT: next_r.tx_off[!post_ch] = 1'b0;
        PA_INH: next_r.tf_inh = 1'b1;
        PA_UNINH: next_r.tf_inh = 1'b0;
        default: next_r.post = PA_NONE;
      endcase
    end

    // software reset and master clear
    if (soft_rst || r.mclr)
    begin
      next_r.st = ST_IDLE;
      next_r.tx_off = '0;
      next_r.me = 1'b0;
      next_r.bcast = 1'b0;
      next_r.tf = 1'b0;
      next_r.tf_inh = 1'b0;
      next_r.bitw = '0;
      next_r.ram_req = 1'b0;
      next_r.tx_req = 1'b0;
      next_r.tt_load = 1'b0;
    end

    // a loopback failure wins over any clear in the same cycle
    if (loop_fail && !next_r.tf_inh)
    begin
      next_r.tf = 1'b1;
      next_r.tf_loop = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.post <= PA_NONE;
      r.rpo_n <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign tx_req = r.tx_req;
  assign tx_with_data = r.send_data;
  assign tx_data = r.tx_data;
  assign tx_shutdown = r.tx_off;
  assign status_me = r.me;
  assign status_bcast = r.bcast;
  assign status_tf = r.tf;
  assign bit_word = r.bitw;
  assign ram_req = r.ram_req;
  assign ram_we = r.ram_we;
  assign ram_addr = r.ram_addr;
  assign ram_wdata = r.ram_wdata;
  assign time_tag_load = r.tt_load;
  assign time_tag_value = r.tt_value;
  assign reset_pulse_out_n = r.rpo_n;

endmodule : rtmch_mode_code_handler
`default_nettype wire

//--- rtmch_pkg.sv
`default_nettype none
package rtmch_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int RT_RESET_DELAY_US = 8;
  localparam int RT_RESET_DELAY_CYC = RT_RESET_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int RST_PULSE_CYC = 2;

  // ----------------------------------------------------------------
  // apb register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_START = 8'h00;
  localparam logic [7:0] REG_CFG2 = 8'h04;
  localparam logic [7:0] REG_CFG3 = 8'h08;
  localparam logic [7:0] REG_CFG7 = 8'h0c;
  localparam logic [7:0] REG_RTADDR = 8'h10;
  localparam logic [7:0] REG_ILLEGAL = 8'h14;
  localparam logic [7:0] REG_PTR_TX = 8'h18;
  localparam logic [7:0] REG_PTR_RX = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_BITW = 8'h24;
  localparam logic [7:0] REG_LASTCMD = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int START_SOFT_RST = 0;
  localparam int CFG2_LOAD_TT = 5;
  localparam int CFG3_ENH_MODE = 15;
  localparam int CFG3_ENH_MC = 0;
  localparam int CFG7_RST_PULSE = 0;
  localparam int CFG7_ENH_TT = 2;
  localparam int BITW_CCE = 1;
  localparam int BITW_LWC = 2;
  localparam int BITW_HWC = 3;
  localparam int CMD_ADDR_HI = 15;
  localparam int CMD_ADDR_LO = 11;
  localparam int CMD_TR = 10;
  localparam int CMD_SA_HI = 9;
  localparam int CMD_SA_LO = 5;
  localparam int CMD_MC_HI = 4;
  localparam int CMD_MC_LO = 0;

  // ----------------------------------------------------------------
  // codes and addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] BCAST_ADDR = 5'h1f;
  localparam logic [4:0] SA_MODE_A = 5'h00;
  localparam logic [4:0] SA_MODE_B = 5'h1f;
  localparam logic [4:0] MC_SHUT = 5'h04;
  localparam logic [4:0] MC_UNSHUT = 5'h05;
  localparam logic [4:0] MC_INH = 5'h06;
  localparam logic [4:0] MC_UNINH = 5'h07;
  localparam logic [4:0] MC_RST = 5'h08;
  localparam logic [4:0] MC_RSV_LO = 5'h09;
  localparam logic [4:0] MC_RSV_HI = 5'h0f;
  localparam logic [4:0] MC_TVW = 5'h10;
  localparam logic [4:0] MC_SYNC = 5'h11;
  localparam logic [4:0] MC_TLC = 5'h12;
  localparam logic [1:0] WC_NONE = 2'h0;
  localparam logic [1:0] WC_ONE = 2'h1;
  localparam logic [15:0] RAM_TVW_RX = 16'h0110;
  localparam logic [15:0] RAM_SYNC_RX = 16'h0111;
  localparam logic [15:0] RAM_TLC_RX = 16'h0112;
  localparam logic [15:0] RAM_TLC_BC = 16'h0132;
  localparam logic [15:0] RAM_TVW_TX = 16'h0120;
  localparam logic [15:0] RAM_SYNC_TX = 16'h0121;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RAM = 4'b0010,
    ST_SEND = 4'b0100,
    ST_RST = 4'b1000
  } rtmch_state_t;

  typedef enum logic [2:0] {
    PA_NONE = 3'h0,
    PA_SHUT = 3'h1,
    PA_UNSHUT = 3'h2,
    PA_INH = 3'h3,
    PA_UNINH = 3'h4
  } rtmch_post_t;
endpackage : rtmch_pkg
`default_nettype wire

//--- rtmch_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module rtmch_far_end (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic tx_req, // reply start
  output logic tx_done, // reply sent
  input wire logic ram_req, // ram request
  input wire logic [15:0] ram_addr, // ram address
  output logic [15:0] ram_rdata, // ram data
  output logic ram_ack // ram done
);
  logic [3:0] tc;
  logic [3:0] rc;
  logic slow;
  // answers alternate prompt and slow; idle read data churns
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tc <= 4'h0;
      rc <= 4'h0;
      slow <= 1'b0;
      tx_done <= 1'b0;
      ram_ack <= 1'b0;
    end
    else
    begin
      tx_done <= (tc == 4'h1);
      tc <= tx_req ? (slow ? 4'h9 : 4'h2) : tc - {3'h0, tc != 4'h0};
      ram_ack <= ram_req && !ram_ack && rc == (slow ? 4'h5 : 4'h1);
      rc <= (ram_req && !ram_ack) ? rc + 4'h1 : 4'h0;
      ram_rdata <= (ram_req && !ram_ack) ? ram_addr ^ 16'h5a5a : ~ram_rdata;
      if (tx_done)
        slow <= !slow;
    end
  end
endmodule : rtmch_far_end
`default_nettype wire

//--- rtmch_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rtmch_checker
  import rtmch_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic msg_valid, // msg
  input wire logic [15:0] msg_cmd, // cmd
  input wire logic msg_parity_ok, // parity
  input wire logic [1:0] msg_words, // words
  input wire logic tx_req, // reply
  input wire logic tx_with_data, // with data
  input wire logic [15:0] tx_data, // data
  input wire logic tx_done, // sent
  input wire logic [1:0] tx_shutdown, // blocked
  input wire logic ram_req, // ram
  input wire logic ram_we, // write
  input wire logic [15:0] ram_addr, // addr
  input wire logic [15:0] ram_rdata, // rdata
  input wire logic ram_ack, // ack
  input wire logic time_tag_load, // tt
  input wire logic reset_pulse_out_n // pulse
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  pulse_width_a: assert property (
    $fell(reset_pulse_out_n) |=> !reset_pulse_out_n ##1 reset_pulse_out_n)
    else $error("reset pulse width");
  bad_quiet_a: assert property (
    msg_valid && !msg_parity_ok |=> (!tx_req && !ram_req) [*4])
    else $error("bad command answered");
  bcast_quiet_a: assert property (
    msg_valid && msg_cmd[15:11] == BCAST_ADDR |=> !tx_req [*8])
    else $error("broadcast answered");
  extra_data_a: assert property (
    msg_valid && msg_words != WC_NONE && msg_cmd[4:0] inside {[MC_SHUT:MC_RSV_HI]}
    |=> !tx_req [*8])
    else $error("extra data answered");
  shut_edge_a: assert property (
    |(tx_shutdown & ~$past(tx_shutdown))
    |-> $past(tx_done) || $past(msg_valid && msg_cmd[15:11] == BCAST_ADDR))
    else $error("shutdown before status sent");
  ram_hold_a: assert property (
    ram_req && !ram_ack |=> ram_req && $stable(ram_addr))
    else $error("ram request dropped");
  vec_data_a: assert property (
    tx_req && $past(ram_ack) && !$past(ram_we) |-> tx_with_data && tx_data == $past(ram_rdata))
    else $error("reply word not ram word");
  tt_pulse_a: assert property (
    time_tag_load |=> !time_tag_load)
    else $error("time tag load too long");
  cover property (tx_req && tx_with_data);
  cover property (!reset_pulse_out_n);
  cover property (time_tag_load);
endmodule : rtmch_checker
bind rtmch_mode_code_handler rtmch_checker u_chk (.pclk(pclk), .presetn(presetn),
  .msg_valid(msg_valid), .msg_cmd(msg_cmd), .msg_parity_ok(msg_parity_ok),
  .msg_words(msg_words), .tx_req(tx_req), .tx_with_data(tx_with_data), .tx_data(tx_data),
  .tx_done(tx_done), .tx_shutdown(tx_shutdown), .ram_req(ram_req), .ram_we(ram_we),
  .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_ack(ram_ack),
  .time_tag_load(time_tag_load), .reset_pulse_out_n(reset_pulse_out_n));
`default_nettype wire

//--- tb_rt_mode_code_handler.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rt_mode_code_handler;
  import rtmch_pkg::*;
  // f: ok, reply, with data, msg error, bcast, shutdown[1:0], one data word
  typedef struct packed {logic [15:0] cmd; logic [7:0] f; logic [15:0] d;} rtmch_row_t;
  localparam rtmch_row_t ROWS [18] = '{'{16'h2c10, 8'he0, 16'h5b7a}, '{16'h2c04, 8'hc4, 16'h0},
    '{16'h2c04, 8'h95, 16'h0}, '{16'h2804, 8'h94, 16'h0}, '{16'hfc06, 8'h8c, 16'h0},
    '{16'h2c07, 8'hc4, 16'h0}, '{16'h2c05, 8'hc0, 16'h0}, '{16'h2c09, 8'hd0, 16'h0},
    '{16'h2c0a, 8'hc0, 16'h0}, '{16'h2ff2, 8'he0, 16'h2c0a}, '{16'h2ff2, 8'he0, 16'h2c0a},
    '{16'h3410, 8'h80, 16'h0}, '{16'h2c10, 8'h00, 16'h0}, '{16'h2c11, 8'he0, 16'h5b7b},
    '{16'h2811, 8'hc1, 16'h1234}, '{16'h2812, 8'hc1, 16'h0}, '{16'h2c04, 8'hc4, 16'h0},
    '{16'hf812, 8'h8d, 16'h0}};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic msg_valid = 1'b0, mok = 1'b0, lf = 1'b0, pready, pslverr, er, tx_req, tx_with_data;
  logic tx_done;
  logic status_me, status_bcast, status_tf, ram_req, ram_we, ram_ack, time_tag_load, rpo_n;
  logic [1:0] msg_words = 2'h0, tx_shutdown;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] msg_cmd = 16'h0, msg_data = 16'h0, tx_data, bit_word, ram_addr, ram_wdata;
  logic [15:0] ram_rdata, time_tag_value, tt_seen = 16'h0, wa = 16'h0;
  int num_errors = 0, tests_run = 0, lowc = 0, n;
  rtmch_mode_code_handler #(.RST_DELAY_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid),
    .msg_cmd(msg_cmd), .msg_sync_ok(mok), .msg_manch_ok(mok), .msg_parity_ok(mok),
    .msg_words(msg_words), .msg_data(msg_data), .msg_channel(1'b0), .loop_fail(lf),
    .tx_req(tx_req), .tx_with_data(tx_with_data), .tx_data(tx_data), .tx_done(tx_done),
    .tx_shutdown(tx_shutdown), .status_me(status_me), .status_bcast(status_bcast),
    .status_tf(status_tf), .bit_word(bit_word), .ram_req(ram_req), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ram_ack(ram_ack),
    .time_tag_load(time_tag_load), .time_tag_value(time_tag_value),
    .hardware_master_clear_in(1'b0), .reset_pulse_out_n(rpo_n));
  rtmch_far_end far (.pclk(pclk), .presetn(presetn), .tx_req(tx_req), .tx_done(tx_done),
    .ram_req(ram_req), .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_ack(ram_ack));
  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    if (time_tag_load === 1'b1) tt_seen <= time_tag_value;
    if (ram_ack === 1'b1 && ram_we === 1'b1) wa <= ram_addr;
    if (rpo_n === 1'b0) lowc <= lowc + 1;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic msg(input rtmch_row_t r);
    logic got = 1'b0;
    logic wd = 1'b0;
    logic [15:0] td = 16'h0;
    @(posedge pclk);
    msg_valid <= 1'b1;
    msg_cmd <= r.cmd;
    msg_words <= {1'b0, r.f[0]};
    msg_data <= r.d;
    mok <= r.f[7];
    @(posedge pclk);
    msg_valid <= 1'b0;
    repeat (26)
    begin
      @(posedge pclk);
      if (tx_req === 1'b1)
      begin
        got = 1'b1;
        wd = tx_with_data;
        td = tx_data;
      end
    end
    chk(got, r.f[6]);
    chk(wd, r.f[5]);
    if (r.f[5]) chk(td, r.d);
    chk(status_me, r.f[4]);
    chk(status_bcast, r.f[3]);
    chk(tx_shutdown, r.f[2:1]);
  endtask : msg
  task summarize;
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    summarize();
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    chk(rpo_n, 1'b1);
    chk(tx_shutdown, 2'h0);
    presetn <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[15:0], 16'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, REG_RTADDR, 32'h5);
    apb(1'b1, REG_CFG3, 32'h8001);
    apb(1'b1, REG_CFG7, 32'h1);
    apb(1'b1, REG_CFG2, 32'h20);
    apb(1'b1, REG_ILLEGAL, 32'h200);
    for (int i = 0; i < 18; i++) msg(ROWS[i]);
    chk(tt_seen, 16'h1234);
    chk(wa, 16'h0132);
    n = lowc;
    msg('{16'h2c08, 8'hc0, 16'h0});
    chk(16'(lowc - n), 16'h2);
    msg('{16'h2c04, 8'hc4, 16'h0});
    msg('{16'h2804, 8'h94, 16'h0});
    chk(bit_word, 16'h0002);
    apb(1'b1, REG_START, 32'h1);
    @(posedge pclk);
    chk(status_me, 1'b0);
    chk(tx_shutdown, 2'h0);
    lf <= 1'b1;
    @(posedge pclk);
    lf <= 1'b0;
    @(posedge pclk);
    chk(status_tf, 1'b1);
    msg('{16'hfc08, 8'h88, 16'h0});
    chk(status_tf, 1'b1);
    apb(1'b1, REG_CFG7, 32'h5);
    msg('{16'h2811, 8'hc1, 16'h1235});
    chk(tt_seen, 16'h1234);
    summarize();
  end
endmodule : tb_rt_mode_code_handler
`default_nettype wire
